//--- pkg/itl_pkg.sv
// Constants and carrier types for the ITA2 terminal link error logic
// Function
// RQ1 - Received character with bad parity is dropped; an at-sign prints instead.
// RQ2 - Printer not accepting beyond timeout raises the fault lamp.
// RQ3 - Fault lamp stays lit while receive buffer overflow persists; data may drop.
// RQ4 - Line transmit blocked past timeout prints LINE TX FAIL, goes off line.
// RQ5 - Punch blocked past timeout prints PUNCH FAIL, halts punch output.
// RQ6 - Punch output restarts by itself once the punch fault clears.
// RQ7 - Punch attached but unpowered also reports PUNCH FAIL.
// RQ8 - Control-E sends code 09; remote answers with its answer-back.
// RQ9 - Off line, form set marks top of form; form feed advances to it.
// RQ10 - Figure or letter shift inserted automatically when case must change.
// RQ11 - Every transmission to line or punch starts with a shift character; code forces one only before the first non-control key after reset.
// RQ12 - Printed line limited to 69 characters; excess forces a new line.
// RQ13 - Control-N sends 1b, control-O sends 1f, control-@ sends 00.
// RQ14 - Line feed is 02, return is 08 in both cases; control-G sounds buzzer.
package itl_pkg;
    localparam int unsigned CLK_HZ        = 40_000_000;
    // Short stall timeout; raise it for a slow mechanism
    localparam int unsigned STALL_TIME_US = 100;
    localparam int unsigned STALL_CYCLES  = CLK_HZ / 1_000_000 * STALL_TIME_US;
    localparam logic [4:0] C_NULL   = 5'h00;
    localparam logic [4:0] C_ENQ    = 5'h09;
    localparam logic [4:0] C_LF     = 5'h02;
    localparam logic [4:0] C_CR     = 5'h08;
    localparam logic [4:0] C_FIGS   = 5'h1b;
    localparam logic [4:0] C_LTRS   = 5'h1f;
    localparam logic [7:0] A_AT     = 8'h40;
    localparam logic [7:0] A_LF     = 8'h0a;
    localparam logic [7:0] A_CR     = 8'h0d;
    localparam logic [7:0] A_FF     = 8'h0c;
    localparam logic [7:0] K_ENQ    = 8'h05;
    localparam logic [7:0] K_BEL    = 8'h07;
    localparam logic [7:0] K_SO     = 8'h0e;
    localparam logic [7:0] K_SI     = 8'h0f;
    localparam logic [6:0] LINE_MAX = 7'd69;
    localparam int unsigned FORM_LINES = 66;
    // Key code carried with the case it needs
    typedef struct packed {
        logic       figs;   // needs figure case
        logic       any;    // valid in either case
        logic [4:0] code;
    } itl_sym_t;
    // Printer message selector
    typedef enum logic [1:0] {ITL_MSG_NONE, ITL_MSG_LINE, ITL_MSG_PUNCH} itl_msg_t;
endpackage

//--- hdl/itl_link.sv
// ITA2 terminal: key encoding, shift insertion, error handling, print path
`timescale 1ns/10ps
module itl_link
(
    input  wire logic               clk_in,
    input  wire logic               rst_n_in,
    input  wire logic               key_valid_in,
    input  wire itl_pkg::itl_sym_t  key_sym_in,
    input  wire logic [7:0]         key_ctrl_in,
    input  wire logic               key_is_ctrl_in,
    output logic                    key_ready_out,
    output logic                    line_valid_out,
    output logic [4:0]              line_code_out,
    input  wire logic               line_ready_in,
    output logic                    punch_valid_out,
    output logic [4:0]              punch_code_out,
    input  wire logic               punch_ready_in,
    input  wire logic               punch_attached_in,
    input  wire logic               punch_power_in,
    input  wire logic               rx_valid_in,
    input  wire logic [7:0]         rx_char_in,
    input  wire logic               rx_parity_err_in,
    input  wire logic               rx_overflow_in,
    input  wire logic               form_set_in,
    input  wire logic               form_feed_in,
    output logic                    prn_valid_out,
    output logic [7:0]              prn_char_out,
    input  wire logic               prn_ready_in,
    output logic                    online_out,
    input  wire logic               go_online_in,
    output logic                    fault_lamp_out,
    output logic                    buzzer_out,
    output logic                    punch_halted_out
);
    import itl_pkg::*;

    // Pin inputs pass three flops; change accepted when stages 2 and 3 agree
    logic [2:0] att_s;
    logic [2:0] pwr_s;
    logic       att_ok;
    logic       pwr_ok;
    always_ff @(posedge clk_in)
    begin
        if (!rst_n_in)
        begin
            att_s  <= 3'h0;
            pwr_s  <= 3'h0;
            att_ok <= 1'b0;
            pwr_ok <= 1'b0;
        end
        else
        begin
            att_s <= {att_s[1:0], punch_attached_in};
            pwr_s <= {pwr_s[1:0], punch_power_in};
            if (att_s[1] == att_s[2])
                att_ok <= att_s[2];
            if (pwr_s[1] == pwr_s[2])
                pwr_ok <= pwr_s[2];
        end
    end

    // Encoder: shift character first, then the code
    logic       figs_case;
    logic       synced;
    logic       pend_valid;
    logic [4:0] pend_code;
    logic       tx_valid;
    logic [4:0] tx_code;
    logic       tx_take;
    logic       need_shift;
    logic [4:0] ctl_code;
    logic       ctl_ok;
    always_comb
    begin
        ctl_ok   = 1'b1;
        ctl_code = C_NULL;                               // see RQ13
        case (key_ctrl_in)
            K_ENQ: ctl_code = C_ENQ;                     // see RQ8
            K_SO:  ctl_code = C_FIGS;                    // see RQ13
            K_SI:  ctl_code = C_LTRS;                    // see RQ13
            A_LF:  ctl_code = C_LF;                      // see RQ14
            A_CR:  ctl_code = C_CR;                      // see RQ14
            8'h00: ctl_code = C_NULL;
            K_BEL: ctl_ok = 1'b0;
            default: ctl_ok = 1'b0;
        endcase
    end
    assign need_shift = !key_is_ctrl_in &&
        (!synced || (!key_sym_in.any && key_sym_in.figs != figs_case)); // see RQ10 RQ11

    // Two-entry buffer between encoder and line/punch fan-out
    logic [4:0] fifo_mem [2];
    logic       wr_ptr;
    logic       rd_ptr;
    logic [1:0] fifo_cnt;
    logic       fifo_ready;
    logic       drain;
    assign fifo_ready = (fifo_cnt != 2'd2);
    assign tx_take    = tx_valid && fifo_ready;

    always_ff @(posedge clk_in)
    begin
        if (!rst_n_in)
        begin
            figs_case  <= 1'b0;
            synced     <= 1'b0;
            pend_valid <= 1'b0;
            pend_code  <= C_NULL;
            tx_valid   <= 1'b0;
            tx_code    <= C_NULL;
            key_ready_out <= 1'b1;
        end
        else if (tx_valid && !tx_take)
            key_ready_out <= 1'b0;
        else if (tx_valid && tx_take && pend_valid)
        begin
            tx_code    <= pend_code;
            pend_valid <= 1'b0;
        end
        else
        begin
            tx_valid      <= 1'b0;
            key_ready_out <= 1'b1;
            if (key_valid_in && key_ready_out && (!key_is_ctrl_in || ctl_ok))
            begin
                tx_valid      <= 1'b1;
                key_ready_out <= 1'b0;
                if (need_shift)
                begin
                    tx_code    <= key_sym_in.figs ? C_FIGS : C_LTRS;  // see RQ10 RQ11
                    figs_case  <= key_sym_in.figs;
                    synced     <= 1'b1;
                    pend_valid <= 1'b1;
                    pend_code  <= key_sym_in.code;
                end
                else
                    tx_code <= key_is_ctrl_in ? ctl_code : key_sym_in.code;
                if (key_is_ctrl_in && ctl_code == C_FIGS)
                    figs_case <= 1'b1;
                if (key_is_ctrl_in && ctl_code == C_LTRS)
                    figs_case <= 1'b0;
            end
        end
    end

    // Fan-out: a word leaves when every live sink took it
    logic line_done;
    logic punch_done;
    logic punch_live;
    logic punch_halt;
    assign punch_live = att_ok && !punch_halt;
    assign drain = (fifo_cnt != 2'd0) && (line_done || !online_out)
                   && (punch_done || !punch_live);
    always_ff @(posedge clk_in)
    begin
        if (!rst_n_in)
        begin
            wr_ptr   <= 1'b0;
            rd_ptr   <= 1'b0;
            fifo_cnt <= 2'd0;
            fifo_mem[0] <= C_NULL;
            fifo_mem[1] <= C_NULL;
        end
        else
        begin
            if (tx_take)
            begin
                fifo_mem[wr_ptr] <= tx_code;
                wr_ptr           <= !wr_ptr;
            end
            if (drain)
                rd_ptr <= !rd_ptr;
            fifo_cnt <= fifo_cnt + {1'b0, tx_take} - {1'b0, drain};
        end
    end

    // Line and punch handshakes, each with its stall timer
    logic [31:0] line_wait;
    logic [31:0] punch_wait;
    logic        line_fail;
    logic        punch_fail;
    always_ff @(posedge clk_in)
    begin
        if (!rst_n_in)
        begin
            line_valid_out  <= 1'b0;
            line_code_out   <= C_NULL;
            punch_valid_out <= 1'b0;
            punch_code_out  <= C_NULL;
            line_done  <= 1'b0;
            punch_done <= 1'b0;
            line_wait  <= 32'h0;
            punch_wait <= 32'h0;
            online_out <= 1'b1;
            punch_halt <= 1'b0;
            line_fail  <= 1'b0;
            punch_fail <= 1'b0;
        end
        else
        begin
            line_fail  <= 1'b0;
            punch_fail <= 1'b0;
            if (drain)
            begin
                line_done  <= 1'b0;
                punch_done <= 1'b0;
            end
            if (go_online_in)
                online_out <= 1'b1;
            line_valid_out <= online_out && fifo_cnt != 2'd0 && !line_done && !drain;
            line_code_out  <= fifo_mem[rd_ptr];
            if (line_valid_out && line_ready_in)
            begin
                line_done      <= 1'b1;
                line_valid_out <= 1'b0;
                line_wait      <= 32'h0;
            end
            else if (line_valid_out)
            begin
                line_wait <= line_wait + 32'h1;
                if (line_wait == STALL_CYCLES - 1)                 // see RQ4
                begin
                    online_out     <= 1'b0;
                    line_valid_out <= 1'b0;
                    line_wait      <= 32'h0;
                    line_fail      <= 1'b1;
                end
            end
            punch_valid_out <= punch_live && pwr_ok && fifo_cnt != 2'd0
                               && !punch_done && !drain;
            punch_code_out  <= fifo_mem[rd_ptr];
            if (punch_halt && pwr_ok && punch_ready_in)
                punch_halt <= 1'b0;                                // see RQ6
            if (punch_valid_out && punch_ready_in)
            begin
                punch_done      <= 1'b1;
                punch_valid_out <= 1'b0;
                punch_wait      <= 32'h0;
            end
            else if (punch_live && fifo_cnt != 2'd0 && !punch_done)
            begin
                punch_wait <= punch_wait + 32'h1;                  // see RQ7
                if (punch_wait == STALL_CYCLES - 1)                // see RQ5
                begin
                    punch_halt      <= 1'b1;
                    punch_valid_out <= 1'b0;
                    punch_wait      <= 32'h0;
                    punch_fail      <= 1'b1;
                end
            end
        end
    end
    assign punch_halted_out = punch_halt;

    // Print path: received chars, failure messages, form feed, line limit
    localparam logic [7:0] MSG_L [12] = '{8'h4c,8'h49,8'h4e,8'h45,8'h20,8'h54,
                                          8'h58,8'h20,8'h46,8'h41,8'h49,8'h4c};
    localparam logic [7:0] MSG_P [10] = '{8'h50,8'h55,8'h4e,8'h43,8'h48,8'h20,
                                          8'h46,8'h41,8'h49,8'h4c};
    itl_msg_t   msg;
    logic [3:0] msg_idx;
    logic       msg_p_req;
    logic       msg_l_req;
    logic [6:0] col;
    logic [6:0] form_line;
    logic [6:0] lines_left;
    logic [31:0] prn_wait;
    logic       ff_busy;
    always_ff @(posedge clk_in)
    begin
        if (!rst_n_in)
        begin
            prn_valid_out <= 1'b0;
            prn_char_out  <= A_AT;
            msg        <= ITL_MSG_NONE;
            msg_idx    <= 4'h0;
            msg_l_req  <= 1'b0;
            msg_p_req  <= 1'b0;
            col        <= 7'd0;
            form_line  <= 7'd0;
            lines_left <= 7'd0;
            ff_busy    <= 1'b0;
            prn_wait   <= 32'h0;
            fault_lamp_out <= 1'b0;
            buzzer_out <= 1'b0;
        end
        else
        begin
            // Requests latch so a failure during another message is not lost
            if (line_fail)
                msg_l_req <= 1'b1;
            if (punch_fail)
                msg_p_req <= 1'b1;
            buzzer_out <= key_valid_in && key_ready_out && key_is_ctrl_in
                          && key_ctrl_in == K_BEL;                 // see RQ14
            if (form_set_in && !online_out)
                form_line <= 7'd0;                                 // see RQ9
            if (prn_valid_out && !prn_ready_in)
                prn_wait <= prn_wait + 32'h1;
            else
                prn_wait <= 32'h0;
            fault_lamp_out <= rx_overflow_in                       // see RQ3
                || (prn_wait >= STALL_CYCLES - 1)                  // see RQ2
                || (fault_lamp_out && prn_valid_out && !prn_ready_in);
            if (prn_valid_out && prn_ready_in)
                prn_valid_out <= 1'b0;
            else if (!prn_valid_out)
            begin
                case (msg)
                    ITL_MSG_LINE, ITL_MSG_PUNCH:
                    begin
                        prn_valid_out <= 1'b1;
                        prn_char_out  <= (msg == ITL_MSG_LINE) ? MSG_L[msg_idx]
                                                              : MSG_P[msg_idx];
                        msg_idx <= msg_idx + 4'h1;
                        if ((msg == ITL_MSG_LINE && msg_idx == 4'd11) ||
                            (msg == ITL_MSG_PUNCH && msg_idx == 4'd9))
                        begin
                            msg     <= ITL_MSG_NONE;
                            msg_idx <= 4'h0;
                        end
                    end
                    default:
                    begin
                        if (msg_l_req || line_fail)
                        begin
                            msg       <= ITL_MSG_LINE;             // see RQ4
                            msg_l_req <= 1'b0;
                        end
                        else if (msg_p_req || punch_fail)
                        begin
                            msg       <= ITL_MSG_PUNCH;            // see RQ5 RQ7
                            msg_p_req <= 1'b0;
                        end
                        else if (ff_busy)
                        begin
                            prn_valid_out <= 1'b1;
                            prn_char_out  <= A_LF;                 // see RQ9
                            lines_left    <= lines_left - 7'd1;
                            ff_busy       <= (lines_left != 7'd1);
                            form_line     <= 7'd0;
                        end
                        else if (form_feed_in && !online_out)
                        begin
                            ff_busy    <= 1'b1;
                            lines_left <= 7'(FORM_LINES) - form_line;
                            col        <= 7'd0;
                        end
                        else if (col == LINE_MAX)
                        begin
                            prn_valid_out <= 1'b1;
                            prn_char_out  <= A_LF;                 // see RQ12
                            col           <= 7'd0;
                        end
                        else if (rx_valid_in && !rx_overflow_in)
                        begin
                            prn_valid_out <= 1'b1;
                            prn_char_out  <= rx_parity_err_in ? A_AT : rx_char_in; // see RQ1
                            if (rx_char_in == A_CR || rx_char_in == A_LF)
                                col <= 7'd0;
                            else
                                col <= col + 7'd1;
                            if (rx_char_in == A_LF)
                                form_line <= (form_line == 7'(FORM_LINES - 1)) ? 7'd0
                                             : form_line + 7'd1;
                        end
                    end
                endcase
            end
        end
    end

    // Assertions
    a_parity_at_print: assert property (@(posedge clk_in) disable iff (!rst_n_in)
        (!prn_valid_out && msg == ITL_MSG_NONE && !msg_l_req && !line_fail && !msg_p_req
         && !punch_fail && !ff_busy && col != LINE_MAX && !(form_feed_in && !online_out)
         && rx_valid_in && !rx_overflow_in && rx_parity_err_in)
        |=> prn_valid_out && prn_char_out == A_AT)                 // see RQ1
        else $error("parity error not printed as at-sign");
    a_overflow_lamp_on: assert property (@(posedge clk_in) disable iff (!rst_n_in)
        rx_overflow_in |=> fault_lamp_out)                         // see RQ3
        else $error("fault lamp dark during overflow");
    a_line_fail_off: assert property (@(posedge clk_in) disable iff (!rst_n_in)
        line_fail |-> !online_out && !line_valid_out)              // see RQ4
        else $error("line failure did not go off line");
    a_punch_fail_halt: assert property (@(posedge clk_in) disable iff (!rst_n_in)
        punch_fail |-> punch_halt && !punch_valid_out)             // see RQ5
        else $error("punch failure did not halt punch");
    a_punch_resume: assert property (@(posedge clk_in) disable iff (!rst_n_in)
        punch_halt && pwr_ok && punch_ready_in |=> !punch_halt)    // see RQ6
        else $error("punch did not resume");
    a_unpowered_no_punch: assert property (@(posedge clk_in) disable iff (!rst_n_in)
        !pwr_ok |=> !punch_valid_out)                              // see RQ7
        else $error("punch offered while unpowered");
    a_line_limit: assert property (@(posedge clk_in) disable iff (!rst_n_in)
        col <= LINE_MAX)                                           // see RQ12
        else $error("printed column beyond limit");
    a_first_is_shift: assert property (@(posedge clk_in) disable iff (!rst_n_in)
        tx_valid && !$past(tx_valid) && !$past(synced) && !$past(key_is_ctrl_in)
        |-> tx_code == C_FIGS || tx_code == C_LTRS)                // see RQ11
        else $error("first transmission not a shift");
    a_enq_code: assert property (@(posedge clk_in) disable iff (!rst_n_in)
        key_valid_in && key_ready_out && key_is_ctrl_in && key_ctrl_in == K_ENQ
        |=> tx_valid && tx_code == C_ENQ)                          // see RQ8
        else $error("control-E not sent as 09");
    c_line_fail: cover property (@(posedge clk_in) line_fail);
    c_punch_resume: cover property (@(posedge clk_in) punch_halt ##1 !punch_halt);
    c_parity_print: cover property (@(posedge clk_in) rx_valid_in && rx_parity_err_in);
    c_form_feed: cover property (@(posedge clk_in) ff_busy ##1 !ff_busy);
endmodule

//--- sim/itl_far_end.sv
// Far end model: remote terminal on the serial line and paper tape punch
`timescale 1ns/10ps
module itl_far_end
(
    input  wire logic       clk_in,
    input  wire logic       line_valid_in,
    input  wire logic [4:0] line_code_in,
    output logic            line_ready_out,
    input  wire logic       punch_valid_in,
    input  wire logic [4:0] punch_code_in,
    output logic            punch_ready_out,
    input  wire logic       punch_power_in,
    input  wire logic       line_stall_in,
    input  wire logic       slow_in,
    output logic            answer_back_out
);
    import itl_pkg::*;
    logic [4:0] line_log[$];
    logic [4:0] punch_log[$];
    logic [1:0] pace;
    initial
    begin
        pace = 2'h0;
        answer_back_out = 1'b0;
        line_ready_out = 1'b0;
        punch_ready_out = 1'b0;
    end
    // Ready moves on the falling edge, away from the sampling edge
    always @(negedge clk_in)
    begin
        pace <= pace + 2'h1;
        line_ready_out <= !line_stall_in && (!slow_in || pace == 2'h3);
        // Unpowered punch never takes a word
        punch_ready_out <= punch_power_in && (!slow_in || pace[0]);
    end
    always @(posedge clk_in)
    begin
        if (line_valid_in && line_ready_out)
        begin
            line_log.push_back(line_code_in);
            if (line_code_in == C_ENQ)
                answer_back_out <= 1'b1;
        end
        if (punch_valid_in && punch_ready_out)
            punch_log.push_back(punch_code_in);
    end
endmodule

//--- sim/tb_itl_link.sv
// Self-checking bench for the ITA2 terminal link error logic
`timescale 1ns/10ps
module tb_itl_link;
    import itl_pkg::*;
    logic       clk, rst_n, kv, kc_sel, k_rdy, l_v, l_rdy, p_v, p_rdy, p_pow;
    logic       rx_v, rx_pe, rx_ov, prn_v, online, lamp, buzz, halted, l_stall, slow;
    logic       ans, fs, ff, prn_rdy;
    itl_sym_t   ks;
    logic [7:0] kc, rx_c, prn_c;
    logic [4:0] l_c, p_c;
    logic [7:0] prn_q[$];
    int         miscompares, total_checks, buzz_n;

    itl_link u_itl_link
    (
        .clk_in(clk), .rst_n_in(rst_n), .key_valid_in(kv), .key_sym_in(ks),
        .key_ctrl_in(kc), .key_is_ctrl_in(kc_sel), .key_ready_out(k_rdy),
        .line_valid_out(l_v), .line_code_out(l_c), .line_ready_in(l_rdy),
        .punch_valid_out(p_v), .punch_code_out(p_c), .punch_ready_in(p_rdy),
        .punch_attached_in(1'b1), .punch_power_in(p_pow), .rx_valid_in(rx_v),
        .rx_char_in(rx_c), .rx_parity_err_in(rx_pe), .rx_overflow_in(rx_ov),
        .form_set_in(fs), .form_feed_in(ff), .prn_valid_out(prn_v),
        .prn_char_out(prn_c), .prn_ready_in(prn_rdy), .online_out(online),
        .go_online_in(1'b0), .fault_lamp_out(lamp), .buzzer_out(buzz),
        .punch_halted_out(halted)
    );
    itl_far_end u_itl_far_end
    (
        .clk_in(clk), .line_valid_in(l_v), .line_code_in(l_c), .line_ready_out(l_rdy),
        .punch_valid_in(p_v), .punch_code_in(p_c), .punch_ready_out(p_rdy),
        .punch_power_in(p_pow), .line_stall_in(l_stall), .slow_in(slow),
        .answer_back_out(ans)
    );

    always @(posedge clk)
    begin
        if (prn_v === 1'b1 && prn_rdy === 1'b1)
            prn_q.push_back(prn_c);
        if (buzz === 1'b1)
            buzz_n++;
    end

    task automatic print_verdict();
        $display("Checks %0d, mismatches %0d", total_checks, miscompares);
        if (miscompares == 0 && total_checks > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask
    task automatic check(input logic [31:0] seen, input logic [31:0] want);
        total_checks++;
        if (seen !== want)
        begin
            miscompares++;
            $display("BAD at %0t: seen %h expected %h", $time, seen, want);
        end
    endtask
    task automatic give_up();
        check(32'h0, 32'h1);
        print_verdict();
    endtask
    task automatic cyc(input int n);
        repeat (n) @(negedge clk);
    endtask
    // Key held until ready was seen before the taking edge
    task automatic send_key(input logic c, input logic [7:0] k, input itl_sym_t s);
        int n;
        @(negedge clk);
        kv = 1'b1;
        kc_sel = c;
        kc = k;
        ks = s;
        for (n = 0; k_rdy !== 1'b1 && n < 200; n++)
            @(negedge clk);
        if (n == 200)
            give_up();
        @(negedge clk);
        kv = 1'b0;
    endtask
    task automatic wait_sz(input int n, input bit prn);
        int k;
        for (k = 0; (prn ? prn_q.size() : u_itl_far_end.line_log.size()) < n; k++)
        begin
            if (k == 400)
                give_up();
            @(negedge clk);
        end
    endtask
    task automatic send_rx(input logic [7:0] c, input logic pe);
        @(negedge clk);
        rx_v = 1'b1;
        rx_c = c;
        rx_pe = pe;
        @(negedge clk);
        rx_v = 1'b0;
    endtask
    function automatic bit has_text(input string s);
        int j;
        for (int i = 0; i + s.len() <= prn_q.size(); i++)
        begin
            for (j = 0; j < s.len() && prn_q[i + j] == s[j]; j++);
            if (j == s.len())
                return 1'b1;
        end
        return 1'b0;
    endfunction

    task automatic t_shift();
        logic [4:0] e[7];
        e = '{C_LTRS, 5'h03, C_FIGS, 5'h0a, 5'h10, C_LTRS, 5'h19};
        slow = 1'b1;
        send_key(1'b0, 8'h00, '{1'b0, 1'b0, 5'h03});
        send_key(1'b0, 8'h00, '{1'b1, 1'b0, 5'h0a});
        send_key(1'b0, 8'h00, '{1'b1, 1'b0, 5'h10});
        send_key(1'b0, 8'h00, '{1'b0, 1'b0, 5'h19});
        wait_sz(7, 1'b0);
        check(u_itl_far_end.punch_log[0], C_LTRS);
        for (int i = 0; i < 7; i++)
            check(u_itl_far_end.line_log[i], e[i]);
        slow = 1'b0;
        u_itl_far_end.line_log.delete();
    endtask
    task automatic t_ctrl();
        logic [7:0] k[6];
        logic [4:0] e[6];
        int b;
        k = '{K_ENQ, K_SO, K_SI, 8'h00, A_LF, A_CR};
        e = '{C_ENQ, C_FIGS, C_LTRS, C_NULL, C_LF, C_CR};
        for (int i = 0; i < 6; i++)
        begin
            send_key(1'b1, k[i], '0);
            wait_sz(i + 1, 1'b0);
            check(u_itl_far_end.line_log[i], e[i]);
        end
        check(ans, 1'b1);
        b = buzz_n;
        send_key(1'b1, K_BEL, '0);
        cyc(10);
        check(buzz_n - b, 1);
        check(u_itl_far_end.line_log.size(), 6);
    endtask
    task automatic t_rx();
        cyc(20);
        prn_q.delete();
        send_rx(8'h41, 1'b1);
        wait_sz(1, 1'b1);
        check(prn_q[0], A_AT);
        cyc(20);
        send_rx(8'h42, 1'b0);
        wait_sz(2, 1'b1);
        check(prn_q[1], 8'h42);
        rx_ov = 1'b1;
        cyc(4);
        check(lamp, 1'b1);
        cyc(6);
        check(lamp, 1'b1);
        rx_ov = 1'b0;
        cyc(4);
        check(lamp, 1'b0);
    endtask
    task automatic t_fail();
        int n;
        l_stall = 1'b1;
        p_pow = 1'b0;
        prn_q.delete();
        send_key(1'b0, 8'h00, '{1'b0, 1'b0, 5'h05});
        for (n = 0; !(online === 1'b0 && halted === 1'b1) && n < STALL_CYCLES + 2000; n++)
            @(negedge clk);
        check(online, 1'b0);
        check(halted, 1'b1);
        cyc(300);
        check(p_v, 1'b0);
        check(has_text("LINE TX FAIL"), 1'b1);
        check(has_text("PUNCH FAIL"), 1'b1);
        l_stall = 1'b0;
        p_pow = 1'b1;
        for (n = 0; halted !== 1'b0 && n < 100; n++)
            @(negedge clk);
        check(halted, 1'b0);
    endtask
    task automatic t_form();
        @(negedge clk);
        fs = 1'b1;
        @(negedge clk);
        fs = 1'b0;
        repeat (3) send_rx(A_LF, 1'b0);
        cyc(5);
        prn_q.delete();
        ff = 1'b1;
        @(negedge clk);
        ff = 1'b0;
        wait_sz(FORM_LINES - 3, 1'b1);
        cyc(10);
        check(prn_q.size(), FORM_LINES - 3);
        check(prn_q[0], A_LF);
    endtask
    task automatic t_stall();
        prn_rdy = 1'b0;
        send_rx(8'h43, 1'b0);
        cyc(100);
        check(lamp, 1'b0);
        cyc(STALL_CYCLES);
        check(lamp, 1'b1);
        prn_rdy = 1'b1;
        cyc(4);
        check(lamp, 1'b0);
    endtask
    // Printer is fed by the receive side; the char after the limit is refused
    task automatic t_limit();
        int i;
        send_rx(A_CR, 1'b0);
        cyc(30);
        prn_q.delete();
        repeat (70) send_rx(8'h41, 1'b0);
        wait_sz(70, 1'b1);
        for (i = 0; i < prn_q.size() && prn_q[i] != A_LF; i++);
        check(i, LINE_MAX);
    endtask

    initial
    begin
        clk = 1'b0;
        forever #12.5 clk = ~clk;
    end
    initial
    begin
        {rst_n, kv, kc_sel, rx_v, rx_pe, rx_ov, l_stall, slow, fs, ff} = '0;
        prn_rdy = 1'b1;
        {kc, rx_c, ks, miscompares, total_checks, buzz_n} = '0;
        p_pow = 1'b1;
        cyc(20);
        rst_n = 1'b1;
        t_shift();
        t_ctrl();
        t_rx();
        t_fail();
        t_form();
        t_stall();
        t_limit();
        print_verdict();
    end
endmodule
